// ---- logic/bfce_host.sv ----
// Purpose: host-side command engine for a byte-wide sector flash
// Assumes: flash pins sampled synchronously to i_ref_clk
// Notes: one command at a time; completion found by toggle-bit polling
`default_nettype none
module bfce_host
  import bfce_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // user command port
  input wire logic i_cmd_valid,
  input wire bfce_pkg::bfce_op_e i_cmd_op,
  input wire logic [bfce_pkg::ADDR_W-1:0] i_cmd_addr,
  input wire logic [bfce_pkg::DATA_W-1:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [bfce_pkg::DATA_W-1:0] o_rdata,
  output logic o_bypass,
  output logic o_suspended,
  // flash pins
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic o_rst_n,
  output logic [bfce_pkg::ADDR_W-1:0] o_addr,
  output logic [bfce_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  input wire logic [bfce_pkg::DATA_W-1:0] i_dq,
  input wire logic i_ready_busy_n
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT, S_RST_LOW, S_RST_HIGH} bfce_state_e;

  bfce_state_e state_r;
  bfce_op_e op_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] data_r;
  logic [2:0] step_r;
  logic [7:0] cnt_r;
  logic first_r;
  logic prev_toggle_r;
  logic start_r;
  logic start_wr_r;
  logic [ADDR_W-1:0] cyc_addr_r;
  logic [DATA_W-1:0] cyc_data_r;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;

  // number of bus cycles per operation
  function automatic logic [2:0] seq_len(input bfce_op_e op, input logic bypass);
    logic [2:0] n;
    n = 3'h1;
    unique case (op)
      OP_PROGRAM: n = bypass ? 3'h2 : 3'h4;
      OP_CHIP_ERASE, OP_SECTOR_ERASE: n = 3'h6;
      OP_BYPASS_ENTER: n = 3'h3;
      OP_BYPASS_EXIT: n = 3'h2;
      OP_READ, OP_SECTOR_ADD, OP_POLL, OP_SUSPEND, OP_RESUME, OP_SW_RESET, OP_HW_RESET: n = 3'h1;
    endcase
    return n;
  endfunction : seq_len

  // address and data of one cycle; unlock addresses are not decoded by the part
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input bfce_op_e op, input logic [2:0] step,
      input logic bypass, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [2:0] s;
    logic [ADDR_W+DATA_W-1:0] w;
    s = (op == OP_PROGRAM && bypass) ? step + 3'h2 : step;
    w = {a, d};
    unique case (op)
      OP_PROGRAM: begin
        unique case (s)
          3'h0: w = {UNLOCK_ADDR1, CMD_UNLOCK1};
          3'h1: w = {UNLOCK_ADDR2, CMD_UNLOCK2};
          3'h2: w = {UNLOCK_ADDR1, CMD_PROGRAM};
          default: w = {a, d};
        endcase
      end
      OP_CHIP_ERASE, OP_SECTOR_ERASE: begin
        unique case (s)
          3'h0, 3'h3: w = {UNLOCK_ADDR1, CMD_UNLOCK1};
          3'h1, 3'h4: w = {UNLOCK_ADDR2, CMD_UNLOCK2};
          3'h2: w = {UNLOCK_ADDR1, CMD_ERASE_SETUP};
          default: w = (op == OP_CHIP_ERASE) ? {UNLOCK_ADDR1, CMD_CHIP_ERASE} : {a, CMD_SECTOR_ERASE};
        endcase
      end
      OP_SECTOR_ADD: w = {a, CMD_SECTOR_ERASE};
      OP_SUSPEND: w = {a, CMD_SUSPEND};
      OP_RESUME: w = {a, CMD_RESUME};
      OP_BYPASS_ENTER: begin
        unique case (s)
          3'h0: w = {UNLOCK_ADDR1, CMD_UNLOCK1};
          3'h1: w = {UNLOCK_ADDR2, CMD_UNLOCK2};
          default: w = {UNLOCK_ADDR1, CMD_BYPASS_ENTER};
        endcase
      end
      OP_BYPASS_EXIT: w = (s == STEP_ZERO) ? {a, CMD_BYPASS_EXIT1} : {a, CMD_BYPASS_EXIT2};
      OP_SW_RESET: w = {a, CMD_SW_RESET};
      OP_READ, OP_POLL, OP_HW_RESET: w = {a, d};
    endcase
    return w;
  endfunction : seq_word

  wire logic [2:0] cur_len = seq_len(op_r, o_bypass);
  wire logic [ADDR_W+DATA_W-1:0] cur_word = seq_word(op_r, step_r, o_bypass, addr_r, data_r);
  wire logic last_step = (step_r + 3'h1 == cur_len);
  wire logic is_read_op = (op_r == OP_READ) || (op_r == OP_POLL);
  // self-timed operations are waited out by polling
  wire logic needs_poll = (op_r == OP_PROGRAM) || (op_r == OP_CHIP_ERASE) ||
                          (op_r == OP_SECTOR_ERASE) || (op_r == OP_SUSPEND) || (op_r == OP_POLL);
  wire logic cur_toggle = cyc_rdata[TOGGLE_BIT];
  // finished once the toggle bit stops and ready/busy is high
  wire logic poll_settled = !first_r && (cur_toggle == prev_toggle_r) && i_ready_busy_n;
  wire logic cnt_end = (cnt_r == 8'h00);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= S_IDLE;
      op_r <= OP_READ;
      addr_r <= '0;
      data_r <= '0;
      step_r <= STEP_ZERO;
      cnt_r <= 8'h00;
      first_r <= 1'b1;
      prev_toggle_r <= 1'b0;
      start_r <= 1'b0;
      start_wr_r <= 1'b0;
      cyc_addr_r <= '0;
      cyc_data_r <= '0;
      o_cmd_ready <= 1'b1;
      o_done <= 1'b0;
      o_rdata <= '0;
      o_bypass <= 1'b0;
      o_suspended <= 1'b0;
      o_rst_n <= 1'b1;
    end else begin
      start_r <= 1'b0;
      o_done <= 1'b0;
      unique case (state_r)
        S_IDLE: begin
          if (i_cmd_valid) begin
            op_r <= i_cmd_op;
            addr_r <= i_cmd_addr;
            data_r <= i_cmd_data;
            step_r <= STEP_ZERO;
            first_r <= 1'b1;
            o_cmd_ready <= 1'b0;
            if (i_cmd_op == OP_HW_RESET) begin
              // pin reset aborts anything running in the part
              o_rst_n <= 1'b0;
              cnt_r <= RP_CNT - 8'h01;
              state_r <= S_RST_LOW;
            end else if (i_cmd_op == OP_POLL) begin
              state_r <= S_POLL;
            end else begin
              state_r <= S_ISSUE;
            end
          end
        end
        S_ISSUE: begin
          // each command byte is an ordinary bus write
          start_r <= 1'b1;
          start_wr_r <= !is_read_op;
          cyc_addr_r <= cur_word[ADDR_W+DATA_W-1:DATA_W];
          cyc_data_r <= cur_word[DATA_W-1:0];
          state_r <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (!last_step) begin
              step_r <= step_r + 3'h1;
              state_r <= S_ISSUE;
            end else if (needs_poll) begin
              state_r <= S_POLL;
            end else begin
              if (op_r == OP_BYPASS_ENTER) o_bypass <= 1'b1;
              if (op_r == OP_BYPASS_EXIT) o_bypass <= 1'b0;
              if (op_r == OP_RESUME) o_suspended <= 1'b0;
              o_rdata <= cyc_rdata;
              o_done <= 1'b1;
              o_cmd_ready <= 1'b1;
              state_r <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          start_r <= 1'b1;
          start_wr_r <= 1'b0;
          cyc_addr_r <= addr_r;
          state_r <= S_POLL_WAIT;
        end
        S_POLL_WAIT: begin
          if (cyc_done) begin
            prev_toggle_r <= cur_toggle;
            first_r <= 1'b0;
            if (poll_settled) begin
              // part is back in array read, last read is the stored byte
              if (op_r == OP_SUSPEND) o_suspended <= 1'b1;
              o_rdata <= cyc_rdata;
              o_done <= 1'b1;
              o_cmd_ready <= 1'b1;
              state_r <= S_IDLE;
            end else begin
              state_r <= S_POLL;
            end
          end
        end
        S_RST_LOW: begin
          if (cnt_end) begin
            o_rst_n <= 1'b1;
            cnt_r <= RH_CNT - 8'h01;
            state_r <= S_RST_HIGH;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        S_RST_HIGH: begin
          if (cnt_end) begin
            o_bypass <= 1'b0;
            o_suspended <= 1'b0;
            o_done <= 1'b1;
            o_cmd_ready <= 1'b1;
            state_r <= S_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
      endcase
    end
  end

  bfce_bus_cycle i_bfce_bus_cycle (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_start(start_r),
    .i_write(start_wr_r),
    .i_addr(cyc_addr_r),
    .i_wdata(cyc_data_r),
    .i_dq(i_dq),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n),
    .o_addr(o_addr),
    .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata)
  );
endmodule : bfce_host
`default_nettype wire

// ---- logic/bfce_pkg.sv ----
// Purpose: shared constants and types for the flash command host controller
// Assumes: byte-wide parallel flash with unlock-sequence commands
// Notes: command codes and bus timing figures are adjustable here
`default_nettype none
package bfce_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;
  localparam int ARRAY_BYTES = 2097152;
  localparam int SECTOR_COUNT = 32;
  localparam int SECTOR_SHIFT = 16;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;

  // bus timing, figures in ns, counts derived from the clock period
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_WP_NS = 35;
  localparam int T_ACC_NS = 70;
  localparam int T_RP_NS = 500;
  localparam int T_RH_NS = 50;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RH_CYC = (T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WP_CNT = 8'(WP_CYC);
  localparam logic [7:0] ACC_CNT = 8'(ACC_CYC);
  localparam logic [7:0] RP_CNT = 8'(RP_CYC);
  localparam logic [7:0] RH_CNT = 8'(RH_CYC);

  // unlock addresses; the device does not decode them, any value works
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;

  // command byte values
  localparam logic [DATA_W-1:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'ha0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [DATA_W-1:0] CMD_SUSPEND = 8'hb0;
  localparam logic [DATA_W-1:0] CMD_RESUME = 8'h30;
  localparam logic [DATA_W-1:0] CMD_BYPASS_ENTER = 8'h20;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT1 = 8'h90;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT2 = 8'h00;
  localparam logic [DATA_W-1:0] CMD_SW_RESET = 8'hf0;

  localparam logic [2:0] STEP_ZERO = 3'h0;

  typedef enum logic [3:0] {
    OP_READ,
    OP_PROGRAM,
    OP_CHIP_ERASE,
    OP_SECTOR_ERASE,
    OP_SECTOR_ADD,
    OP_POLL,
    OP_SUSPEND,
    OP_RESUME,
    OP_BYPASS_ENTER,
    OP_BYPASS_EXIT,
    OP_SW_RESET,
    OP_HW_RESET
  } bfce_op_e;
endpackage : bfce_pkg
`default_nettype wire

// ---- logic/bfce_bus_cycle.sv ----
// Purpose: one asynchronous-bus read or write cycle on the flash pins
// Assumes: strobes active low, data lines released when not writing
// Notes: setup and hold are one clock each around the strobe pulse
`default_nettype none
module bfce_bus_cycle
  import bfce_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // request
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [bfce_pkg::ADDR_W-1:0] i_addr,
  input wire logic [bfce_pkg::DATA_W-1:0] i_wdata,
  input wire logic [bfce_pkg::DATA_W-1:0] i_dq,
  // flash pins
  output logic o_ce_n,
  output logic o_we_n,
  output logic o_oe_n,
  output logic [bfce_pkg::ADDR_W-1:0] o_addr,
  output logic [bfce_pkg::DATA_W-1:0] o_dq,
  output logic o_dq_oe_n,
  // completion
  output logic o_done,
  output logic [bfce_pkg::DATA_W-1:0] o_rdata
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_STROBE, C_HOLD} bfce_cyc_e;
  bfce_cyc_e state_r;
  logic write_r;
  logic [7:0] cnt_r;
  wire logic cnt_end = (cnt_r == 8'h00);
  wire logic [7:0] strobe_len = write_r ? WP_CNT - 8'h01 : ACC_CNT - 8'h01;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r <= C_IDLE;
      write_r <= 1'b0;
      cnt_r <= 8'h00;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_addr <= '0;
      o_dq <= '0;
      o_dq_oe_n <= 1'b1;
      o_done <= 1'b0;
      o_rdata <= '0;
    end else begin
      o_done <= 1'b0;
      unique case (state_r)
        C_IDLE: begin
          if (i_start) begin
            // write and output strobes never overlap, so no contention
            write_r <= i_write;
            o_addr <= i_addr;
            o_dq <= i_wdata;
            o_dq_oe_n <= ~i_write;
            o_ce_n <= 1'b0;
            state_r <= C_SETUP;
          end
        end
        C_SETUP: begin
          o_we_n <= ~write_r;
          o_oe_n <= write_r;
          cnt_r <= strobe_len;
          state_r <= C_STROBE;
        end
        C_STROBE: begin
          if (cnt_end) begin
            if (!write_r) o_rdata <= i_dq;
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
            state_r <= C_HOLD;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        C_HOLD: begin
          // chip select high between cycles puts the part in standby
          o_ce_n <= 1'b1;
          o_dq_oe_n <= 1'b1;
          o_done <= 1'b1;
          state_r <= C_IDLE;
        end
      endcase
    end
  end
endmodule : bfce_bus_cycle
`default_nettype wire

// ---- test/bfce_host_assertions.sv ----
// Purpose: protocol checks on the flash pins of the host engine
// Assumes: one clock domain, synchronous active-high reset
// Notes: write strobe width checked as a fixed two clocks; reset pulse follows the package count RP_CNT
`default_nettype none
module bfce_host_chk
  import bfce_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // command port
  input wire logic i_cmd_valid,
  input wire logic o_cmd_ready,
  input wire logic o_done,
  // flash pins
  input wire logic o_ce_n,
  input wire logic o_we_n,
  input wire logic o_oe_n,
  input wire logic o_rst_n,
  input wire logic [bfce_pkg::ADDR_W-1:0] o_addr,
  input wire logic [bfce_pkg::DATA_W-1:0] o_dq,
  input wire logic o_dq_oe_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // length of the current flash reset pulse, zero while the pin is high
  logic [7:0] rst_low_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) rst_low_r <= 8'h00;
    else rst_low_r <= o_rst_n ? 8'h00 : rst_low_r + 8'h01;
  end
  a_strobe_excl: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and output strobes low together");
  a_we_in_ce: assert property (!o_we_n |-> !o_ce_n && !o_dq_oe_n)
    else $error("write strobe without chip select or data drive");
  a_oe_no_drive: assert property (!o_oe_n |-> !o_ce_n && o_dq_oe_n)
    else $error("host drives data lines during a read");
  a_wp_width: assert property ($fell(o_we_n) |=> !o_we_n ##1 o_we_n)
    else $error("write pulse width wrong");
  a_write_hold: assert property (!o_we_n |-> $stable(o_addr) && $stable(o_dq))
    else $error("address or data moved under the write strobe");
  a_hold_after_we: assert property ($rose(o_we_n) |-> !o_ce_n && !o_dq_oe_n)
    else $error("no hold cycle after write strobe");
  a_take_busy: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready && !o_done)
    else $error("ready stayed high after a take");
  a_done_ready: assert property (o_done |-> o_cmd_ready ##1 !o_done)
    else $error("done not a single pulse with ready");
  a_rst_width: assert property ($rose(o_rst_n) |-> rst_low_r == RP_CNT ##[1:4] o_done)
    else $error("flash reset pulse length or recovery wrong");
  a_standby_idle: assert property (o_cmd_ready |-> o_ce_n && o_we_n && o_oe_n)
    else $error("flash selected while idle");
  c_done: cover property (o_done);
  c_write: cover property ($fell(o_we_n));
  c_hw_reset: cover property ($rose(o_rst_n));
endmodule : bfce_host_chk
bind bfce_host bfce_host_chk i_bfce_host_chk (.i_ref_clk, .i_rst, .i_cmd_valid, .o_cmd_ready, .o_done,
  .o_ce_n, .o_we_n, .o_oe_n, .o_rst_n, .o_addr, .o_dq, .o_dq_oe_n);
`default_nettype wire

// ---- test/bfce_flash_model.sv ----
// Purpose: behavioural byte flash answering the host engine
// Assumes: host keeps strobe order; no clock on the device side
// Notes: busy time counted in 25 ns ticks; one sector protected by default
`default_nettype none
module bfce_flash_model
  import bfce_pkg::*;
#(
  parameter logic [31:0] PROT_MASK = 32'h00000004,
  parameter int PROG_T = 40,
  parameter int ERASE_T = 200,
  parameter int SLEEP_T = 12
) (
  // strobes and reset
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_rst_n,
  // address and data
  input wire logic [bfce_pkg::ADDR_W-1:0] i_addr,
  input wire logic [bfce_pkg::DATA_W-1:0] i_dq,
  output logic [bfce_pkg::DATA_W-1:0] o_dq,
  output logic o_ready_busy_n,
  // supply monitor and power state
  input wire logic i_supply_low,
  output logic o_sleep
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [31:0] ers;
  logic [2:0] step;
  logic bypass, susp, tog, erasing;
  logic [7:0] last, pdat;
  int busy;
  int ticks = 0;
  int addr_tick = 0;
  initial begin
    step = 3'h0; busy = 0; susp = 0; tog = 0; erasing = 0; bypass = 0; last = 8'h00; pdat = 8'h00; ers = 32'h0;
  end
  function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction : rd
  assign o_ready_busy_n = (busy == 0) || susp;
  // sleep once the address has stood still for SLEEP_T ticks; reads still answer
  always #25 ticks++;
  always @(i_addr) addr_tick = ticks;
  assign o_sleep = (ticks - addr_tick) >= SLEEP_T;
  // released lines show the inverse of the last value so a stale sample cannot pass
  assign o_dq = (i_ce_n || i_oe_n) ? ~last : (busy != 0 && !susp) ? {~pdat[7], tog, 6'h00} : rd(i_addr);
  always @(o_dq, i_ce_n, i_oe_n) if (!i_ce_n && !i_oe_n) last = o_dq;
  always @(negedge i_oe_n) if (!i_ce_n && busy > 0 && !susp) tog = ~tog;
  task automatic wr(input logic [7:0] d, input logic [ADDR_W-1:0] a);
    if (d == 8'hf0) step = 3'h0;
    else if (busy != 0) begin
      if (erasing && d == 8'hb0) susp = 1'b1;
      else if (erasing && d == 8'h30 && susp) susp = 1'b0;
      else if (erasing && d == 8'h30) ers[a[20:16]] = !PROT_MASK[a[20:16]];
    end else case (step)
      // unlock cycles are matched on data only
      3'h0: step = (bypass && d == 8'ha0) ? 3'h3 : (bypass && d == 8'h90) ? 3'h7 : (d == 8'haa) ? 3'h1 : 3'h0;
      3'h1: step = (d == 8'h55) ? 3'h2 : 3'h0;
      3'h2: begin
        if (d == 8'h20) bypass = 1'b1;
        step = (d == 8'ha0) ? 3'h3 : (d == 8'h80) ? 3'h4 : 3'h0;
      end
      3'h3: begin
        if (!PROT_MASK[a[20:16]]) mem[a] = rd(a) & d;
        pdat = d; busy = PROG_T; step = 3'h0;
      end
      3'h4: step = (d == 8'haa) ? 3'h5 : 3'h0;
      3'h5: step = (d == 8'h55) ? 3'h6 : 3'h0;
      3'h6: begin
        ers = (d == 8'h10) ? ~PROT_MASK : (d == 8'h30) ? (~PROT_MASK & (32'h1 << a[20:16])) : 32'h0;
        erasing = ers != 0; busy = erasing ? ERASE_T : 0; pdat = 8'h00; step = 3'h0;
      end
      default: begin
        if (d == 8'h00) bypass = 1'b0;
        step = 3'h0;
      end
    endcase
  endtask : wr
  // writes during a supply transition are dropped
  always @(posedge i_we_n) if (i_ce_n === 1'b0 && i_rst_n === 1'b1 && i_supply_low !== 1'b1) wr(i_dq, i_addr);
  always #25 if (busy > 0 && !susp) begin
    busy = busy - 1;
    if (busy == 0 && erasing) begin
      foreach (mem[k]) if (ers[k >> 16]) mem[k] = 8'hff;
      erasing = 1'b0;
    end
  end
  always @(negedge i_rst_n) begin
    step = 3'h0; busy = 0; susp = 0; bypass = 0; erasing = 0;
  end
endmodule : bfce_flash_model
`default_nettype wire

// ---- test/bfce_host_tb_top.sv ----
// Purpose: self-checking bench for the flash host engine against a flash model
// Assumes: one command at a time, done pulse seen at the following edge
// Notes: suspend is only exercised on an idle device, host flags checked
`default_nettype none
module bfce_host_tb_top
  import bfce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 1'b0, i_rst, i_cmd_valid, o_cmd_ready, o_done, o_bypass, o_suspended;
  logic o_ce_n, o_we_n, o_oe_n, o_rst_n, o_dq_oe_n, i_ready_busy_n;
  logic supply_low = 1'b0;
  logic fl_sleep;
  bfce_op_e i_cmd_op;
  logic [ADDR_W-1:0] i_cmd_addr, o_addr;
  logic [DATA_W-1:0] i_cmd_data, o_rdata, o_dq, fl_dq, dq_bus;
  int fails = 0, num_checks = 0, we_cnt = 0, cyc = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  assign dq_bus = o_dq_oe_n ? fl_dq : o_dq;
  always @(negedge o_we_n) we_cnt++;
  bfce_host i_bfce_host (.i_ref_clk, .i_rst, .i_cmd_valid, .i_cmd_op, .i_cmd_addr, .i_cmd_data, .o_cmd_ready,
    .o_done, .o_rdata, .o_bypass, .o_suspended, .o_ce_n, .o_we_n, .o_oe_n, .o_rst_n, .o_addr, .o_dq,
    .o_dq_oe_n, .i_dq(dq_bus), .i_ready_busy_n);
  bfce_flash_model i_bfce_flash_model (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_rst_n(o_rst_n),
    .i_addr(o_addr), .i_dq(dq_bus), .o_dq(fl_dq), .o_ready_busy_n(i_ready_busy_n),
    .i_supply_low(supply_low), .o_sleep(fl_sleep));
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic cmd(input bfce_op_e op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b1; i_cmd_op <= op; i_cmd_addr <= a; i_cmd_data <= d;
    @(posedge i_ref_clk);
    i_cmd_valid <= 1'b0;
    while (o_done !== 1'b1 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
    chk("done_seen", n < 2000, 1);
  endtask : cmd
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    cmd(OP_READ, a, 8'h00);
    chk("rdata", o_rdata, exp);
  endtask : rd_chk
  task automatic t_program;
    int w0;
    w0 = we_cnt;
    cmd(OP_PROGRAM, 21'h000123, 8'h5a);
    chk("prog_writes", we_cnt - w0, 4);
    chk("poll_rdata", o_rdata, 8'h5a);
    chk("ready_pin", i_ready_busy_n, 1'b1);
    rd_chk(21'h000123, 8'h5a);
    cmd(OP_PROGRAM, 21'h000123, 8'ha5);
    rd_chk(21'h000123, 8'h00);
    cmd(OP_PROGRAM, 21'h00ffff, 8'h77);
  endtask : t_program
  task automatic t_bypass;
    int w0;
    cmd(OP_BYPASS_ENTER, 21'h1f0000, 8'h00);
    chk("bypass_on", o_bypass, 1'b1);
    w0 = we_cnt;
    cmd(OP_PROGRAM, 21'h010010, 8'h3c);
    chk("bypass_writes", we_cnt - w0, 2);
    rd_chk(21'h010010, 8'h3c);
    cmd(OP_PROGRAM, 21'h01fffe, 8'h11);
    cmd(OP_BYPASS_EXIT, 21'h000000, 8'h00);
    chk("bypass_off", o_bypass, 1'b0);
  endtask : t_bypass
  task automatic t_erase;
    int w0;
    w0 = we_cnt;
    cmd(OP_SECTOR_ERASE, 21'h010000, 8'h00);
    chk("erase_writes", we_cnt - w0, 6);
    rd_chk(21'h010010, 8'hff);
    rd_chk(21'h01fffe, 8'hff);
    rd_chk(21'h00ffff, 8'h77);
    rd_chk(21'h000123, 8'h00);
  endtask : t_erase
  task automatic t_protect;
    cmd(OP_PROGRAM, 21'h020005, 8'h00);
    rd_chk(21'h020005, 8'hff);
    cmd(OP_CHIP_ERASE, 21'h000000, 8'h00);
    rd_chk(21'h000123, 8'hff);
    rd_chk(21'h00ffff, 8'hff);
  endtask : t_protect
  task automatic t_flags;
    cmd(OP_SUSPEND, 21'h030000, 8'h00);
    chk("suspended", o_suspended, 1'b1);
    cmd(OP_SECTOR_ADD, 21'h030000, 8'h00);
    cmd(OP_RESUME, 21'h030000, 8'h00);
    chk("resumed", o_suspended, 1'b0);
    cmd(OP_PROGRAM, 21'h040001, 8'hc3);
    cmd(OP_POLL, 21'h040001, 8'h00);
    chk("poll_idle", o_rdata, 8'hc3);
    cmd(OP_SW_RESET, 21'h000000, 8'h00);
    rd_chk(21'h040001, 8'hc3);
  endtask : t_flags
  task automatic t_hwreset;
    cmd(OP_BYPASS_ENTER, 21'h000000, 8'h00);
    cmd(OP_HW_RESET, 21'h000000, 8'h00);
    chk("bypass_cleared", o_bypass, 1'b0);
    cmd(OP_PROGRAM, 21'h050002, 8'h0f);
    rd_chk(21'h050002, 8'h0f);
  endtask : t_hwreset
  task automatic t_power;
    @(posedge i_ref_clk);
    supply_low <= 1'b1;
    cmd(OP_PROGRAM, 21'h060003, 8'h12);
    rd_chk(21'h060003, 8'hff);
    @(posedge i_ref_clk);
    supply_low <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    chk("sleep_on", fl_sleep, 1'b1);
    rd_chk(21'h060004, 8'hff);
    chk("sleep_off", fl_sleep, 1'b0);
  endtask : t_power
  // ceiling well above the sum of all erase and poll times
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    i_rst = 1'b1; i_cmd_valid = 1'b0; i_cmd_op = OP_READ; i_cmd_addr = 21'h000000; i_cmd_data = 8'h00;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    t_program();
    t_bypass();
    t_erase();
    t_protect();
    t_flags();
    t_hwreset();
    t_power();
    close_out();
  end
endmodule : bfce_host_tb_top
`default_nettype wire
